// ### tmb_pkg.sv
// Purpose: shared constants and types of the test-mode and binary command handler
// Assumes: 32-bit apb register words, byte-wide command stream from the bus front end
// Notes: step sizes are held in tenths of a hertz
package tmb_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STEP = 8'h04;
  localparam logic [7:0] OFS_RBW = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_DUMP = 8'h10;
  // field positions
  localparam int CTRL_CNT_BIT = 0;
  localparam int CTRL_RBWCAL_BIT = 1;
  localparam int STAT_SRQ_BIT = 11;
  localparam int DUMP_TRIG_BIT = 2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [19:0] STEP_RST = 20'h00000;
  localparam logic [3:0] RBW_RST = 4'h0;
  // step size limits, tenths of a hertz
  localparam logic [19:0] STEP_TG_MAX = 20'h03a98;
  localparam logic [19:0] STEP_FINE_MAX = 20'h01388;
  localparam logic [19:0] STEP_BOARD1 = 20'h0000b;
  localparam logic [19:0] STEP_BOARD2 = 20'h0000c;
  localparam logic [19:0] STEP_BOARD3 = 20'h0000d;
  // bandwidth code for the 30 kHz setting, a plain default
  localparam logic [3:0] BW_CODE_30K = 4'h7;
  // test entry codes
  localparam logic [3:0] TM_OFF = 4'h0;
  localparam logic [3:0] TM_CAL_OFF = 4'h1;
  localparam logic [3:0] TM_REF = 4'h2;
  localparam logic [3:0] TM_REF_CAL_OFF = 4'h3;
  localparam logic [3:0] TM_TRK = 4'h4;
  localparam logic [3:0] TM_TRK_CAL_OFF = 4'h5;
  localparam logic [3:0] TM_SINGLE_LOOP = 4'h6;
  localparam logic [3:0] TM_TG_OFFSET = 4'h7;
  localparam logic [3:0] TM_TUNE_PLOT = 4'h8;
  localparam logic [3:0] TM_BW_ADJ = 4'h9;
  // binary transfer word counts
  localparam logic [11:0] LRN_WORDS = 12'h064;
  localparam logic [11:0] TRACE_WORDS = 12'h7d4;
  // ascii characters
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_6 = 8'h36;
  localparam logic [15:0] CMD_RECALL = 16'h5243;
  localparam logic [15:0] CMD_LRN_IN = 16'h4c49;
  localparam logic [15:0] CMD_LRN_OUT = 16'h4c4f;
  localparam logic [15:0] CMD_TRB_IN = 16'h4249;
  localparam logic [15:0] CMD_TRB_OUT = 16'h424f;
  localparam logic [15:0] CMD_TRA_IN = 16'h4149;
  // binary command in progress
  typedef enum logic [2:0] {
    BC_NONE = 3'b000, BC_LRN_IN = 3'b001, BC_TRA_IN = 3'b010, BC_TRB_IN = 3'b011,
    BC_LRN_OUT = 3'b100, BC_TRB_OUT = 3'b101
  } tmb_bin_cmd_t;
  // controls that the active test mode drives into the instrument
  typedef struct packed {
    logic cal_disable;
    logic cal_offsets_off;
    logic src_ref_10m;
    logic src_tracking;
    logic lo_single_loop;
    logic tg_offset_en;
    logic [19:0] tg_offset;
    logic tune_plot_en;
    logic tune_coarse;
    logic tune_fine_hold;
    logic [2:0] board_prog;
    logic [2:0][3:0] board_bw;
  } tmb_tm_ctrl_t;
endpackage

// ### tmb_word_ctr.sv
// Purpose: loadable down counter of binary words still owed in a transfer
// Assumes: load and dec never in the same cycle; load wins if they are
// Notes: busy is high while words remain
`timescale 1ns/100ps
`default_nettype none
module tmb_word_ctr #(
  parameter int W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic dec,
  input wire logic clr,
  // state
  output logic [W-1:0] count,
  output logic busy,
  output logic last
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // load has priority over dec so a new command starts from a full count; clr overrides both
  assign count_next = clr ? '0 : load ? load_val : (dec && busy) ? count_reg - W'(1) : count_reg;
  assign count = count_reg;
  assign busy = (count_reg != '0);
  assign last = (count_reg == W'(1));

  // count register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule
`default_nettype wire

// ### tmb_test_decode.sv
// Purpose: turns the active test mode into instrument control lines
// Assumes: step size in tenths of a hertz, bandwidth as a board code
// Notes: outputs are registered, one cycle behind their inputs
`timescale 1ns/100ps
`default_nettype none
module tmb_test_decode #(
  parameter logic [3:0] BW_30K = tmb_pkg::BW_CODE_30K
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // settings
  input wire logic [3:0] mode,
  input wire logic [19:0] center_step_size,
  input wire logic [3:0] resolution_bw_setting,
  input wire logic rbw_change,
  input wire logic counter_on,
  input wire logic rbw_calibrated,
  // controls
  output tmb_pkg::tmb_tm_ctrl_t ctrl
);
  tmb_pkg::tmb_tm_ctrl_t ctrl_reg;
  tmb_pkg::tmb_tm_ctrl_t ctrl_next;
  logic [2:0] board_hit;
  logic bw_adj;

  // one-hot board pick for the bandwidth adjust mode
  assign board_hit = {center_step_size == tmb_pkg::STEP_BOARD3, center_step_size == tmb_pkg::STEP_BOARD2,
                      center_step_size == tmb_pkg::STEP_BOARD1};
  assign bw_adj = (mode == tmb_pkg::TM_BW_ADJ);

  // decode of every mode; board words hold their last value between changes
  always_comb begin
    ctrl_next = '0;
    ctrl_next.board_bw = ctrl_reg.board_bw;
    unique case (mode)
      tmb_pkg::TM_CAL_OFF, tmb_pkg::TM_BW_ADJ: ctrl_next.cal_disable = 1'b1;
      tmb_pkg::TM_REF: ctrl_next.src_ref_10m = 1'b1;
      tmb_pkg::TM_REF_CAL_OFF: begin
        ctrl_next.src_ref_10m = 1'b1;
        ctrl_next.cal_disable = 1'b1;
      end
      tmb_pkg::TM_TRK: ctrl_next.src_tracking = 1'b1;
      tmb_pkg::TM_TRK_CAL_OFF: begin
        ctrl_next.src_tracking = 1'b1;
        ctrl_next.cal_disable = 1'b1;
      end
      tmb_pkg::TM_SINGLE_LOOP: ctrl_next.lo_single_loop = 1'b1;
      tmb_pkg::TM_TG_OFFSET: begin
        ctrl_next.tg_offset_en = 1'b1;
        ctrl_next.tg_offset = (center_step_size > tmb_pkg::STEP_TG_MAX) ? tmb_pkg::STEP_TG_MAX : center_step_size;
      end
      tmb_pkg::TM_TUNE_PLOT: begin
        ctrl_next.tune_plot_en = counter_on && rbw_calibrated;
        ctrl_next.tune_coarse = center_step_size > tmb_pkg::STEP_FINE_MAX;
        ctrl_next.tune_fine_hold = !ctrl_next.tune_coarse;
      end
      default: ;
    endcase
    ctrl_next.cal_offsets_off = ctrl_next.cal_disable;
    // the chosen board takes the bandwidth, the other two take 30 kHz
    if (bw_adj && rbw_change && (board_hit != 3'b000)) begin
      ctrl_next.board_prog = 3'b111;
      for (int i = 0; i < 3; i++) begin
        ctrl_next.board_bw[i] = board_hit[i] ? resolution_bw_setting : BW_30K;
      end
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign ctrl = ctrl_reg;
endmodule
`default_nettype wire

// ### tmb_cmd_handler.sv
// Purpose: test-mode selection and binary data mode handling behind the instrument bus
// Assumes: command bytes and bus events come from the bus front end on clk
// Notes: apb slave with zero wait states; unmapped addresses answer pslverr
//
// Contract
// - nine test modes, recall six plus code
// - mode 01 disables calibration and offsets
// - mode 02 routes 10 MHz to input
// - mode 03 10 MHz input, calibration off
// - mode 04 routes tracking generator in
// - mode 05 tracking generator, calibration off
// - mode 06 forces single loop oscillator
// - mode 07 step as offset, capped
// - mode 08 tuning plot when counter, calibrated
// - mode 08 coarse above 500 Hz
// - mode 09 like mode 01 otherwise
// - mode 09 programs boards on change
// - test mode holds until clear, preset
// - binary command makes following bytes binary
// - drop cr or lf after binary command
// - back to ascii after last word
// - binary output streams when talk addressed
// - binary ends trigger, dump mode kept
// - uninterpretable command raises service request
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module tmb_cmd_handler #(
  parameter logic [3:0] BW_30K = tmb_pkg::BW_CODE_30K
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command byte stream from the bus front end
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  // bus events
  input wire logic dev_clear,
  input wire logic inst_preset,
  input wire logic talk_addressed,
  input wire logic trigger_in,
  input wire logic cmd_reject,
  // commands handed to the rest of the parser
  output logic fwd_valid,
  output logic [15:0] fwd_cmd,
  // binary input words
  output logic bin_in_valid,
  output logic [7:0] bin_in_data,
  output logic [11:0] bin_in_index,
  output tmb_pkg::tmb_bin_cmd_t bin_cmd,
  // binary output words
  output logic [11:0] out_word_addr,
  input wire logic [7:0] out_word_data,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  // instrument state
  output logic service_request_line,
  output logic dump_active,
  output logic [1:0] dump_mode,
  output tmb_pkg::tmb_tm_ctrl_t tm_ctrl
);
  typedef enum logic [2:0] {
    PS_CMD1 = 3'b000, PS_CMD2 = 3'b001, PS_RC_DIG = 3'b010, PS_TM_D1 = 3'b011,
    PS_TM_D2 = 3'b100, PS_BIN_IN = 3'b101
  } tmb_pstate_t;

  tmb_pstate_t state_reg, state_next;
  logic [7:0] first_reg, first_next;
  logic [3:0] tens_reg, tens_next;
  logic [3:0] staged_reg, staged_next;
  logic pend_reg, pend_next;
  logic [3:0] active_reg, active_next;
  logic skip_eol_reg, skip_eol_next;
  logic srq_reg, srq_next;
  tmb_pkg::tmb_bin_cmd_t bcmd_reg, bcmd_next;
  logic [31:0] ctrl_reg;
  logic [19:0] step_reg;
  logic [3:0] rbw_reg;
  logic rbw_change_reg;
  logic [1:0] dmode_reg;
  logic trig_pend_reg, dump_act_reg;
  logic out_valid_reg;
  logic [7:0] out_data_reg;
  logic fwd_valid_reg;
  logic [15:0] fwd_cmd_reg;
  logic bin_valid_reg;
  logic [7:0] bin_data_reg;
  logic [11:0] bin_index_reg;

  // apb decode
  logic wr_en, rd_en, hit_ctrl, hit_step, hit_rbw, hit_status, hit_dump, hit_any;
  assign hit_ctrl = (paddr == tmb_pkg::OFS_CTRL);
  assign hit_step = (paddr == tmb_pkg::OFS_STEP);
  assign hit_rbw = (paddr == tmb_pkg::OFS_RBW);
  assign hit_status = (paddr == tmb_pkg::OFS_STATUS);
  assign hit_dump = (paddr == tmb_pkg::OFS_DUMP);
  assign hit_any = hit_ctrl | hit_step | hit_rbw | hit_status | hit_dump;
  assign wr_en = psel && penable && pwrite && hit_any;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // byte classes
  logic is_sep, is_eol, is_digit, is_letter;
  logic [3:0] digit;
  logic [15:0] pair;
  assign is_eol = (in_data == tmb_pkg::CH_CR) || (in_data == tmb_pkg::CH_LF);
  assign is_sep = is_eol || (in_data == tmb_pkg::CH_SP) || (in_data == tmb_pkg::CH_SEMI) ||
    (in_data == tmb_pkg::CH_COMMA);
  assign is_digit = (in_data >= tmb_pkg::CH_0) && (in_data <= tmb_pkg::CH_9);
  assign is_letter = (in_data[7:5] == 3'b010) && (in_data[4:0] != 5'h00) && (in_data[4:0] <= 5'h1a);
  assign digit = 4'(in_data - tmb_pkg::CH_0);
  assign pair = {first_reg, in_data};

  // binary word counters, one for each direction
  logic in_load, in_busy, in_last, out_load, out_busy, out_last, out_take, bin_start, out_clr;
  logic [11:0] in_len, out_len, in_count, out_count;
  logic bin_byte;
  assign bin_byte = in_valid && (state_reg == PS_BIN_IN) && !(skip_eol_reg && is_eol);
  tmb_word_ctr #(.W(12)) u_in_ctr (
    .clk(clk), .rst_b(rst_b), .load(in_load), .load_val(in_len), .dec(bin_byte), .clr(dev_clear || inst_preset),
    .count(in_count), .busy(in_busy), .last(in_last)
  );
  tmb_word_ctr #(.W(12)) u_out_ctr (
    .clk(clk), .rst_b(rst_b), .load(out_load), .load_val(out_len), .dec(out_take), .clr(out_clr),
    .count(out_count), .busy(out_busy), .last(out_last)
  );

  // command recognition for the binary commands
  logic pair_bin_in, pair_bin_out;
  tmb_pkg::tmb_bin_cmd_t pair_cmd;
  always_comb begin
    pair_cmd = tmb_pkg::BC_NONE;
    in_len = '0;
    out_len = '0;
    unique case (pair)
      tmb_pkg::CMD_LRN_IN: begin
        pair_cmd = tmb_pkg::BC_LRN_IN;
        in_len = tmb_pkg::LRN_WORDS;
      end
      tmb_pkg::CMD_TRA_IN: begin
        pair_cmd = tmb_pkg::BC_TRA_IN;
        in_len = tmb_pkg::TRACE_WORDS;
      end
      tmb_pkg::CMD_TRB_IN: begin
        pair_cmd = tmb_pkg::BC_TRB_IN;
        in_len = tmb_pkg::TRACE_WORDS;
      end
      tmb_pkg::CMD_LRN_OUT: begin
        pair_cmd = tmb_pkg::BC_LRN_OUT;
        out_len = tmb_pkg::LRN_WORDS;
      end
      tmb_pkg::CMD_TRB_OUT: begin
        pair_cmd = tmb_pkg::BC_TRB_OUT;
        out_len = tmb_pkg::TRACE_WORDS;
      end
      default: ;
    endcase
  end
  assign pair_bin_in = (in_len != '0);
  assign pair_bin_out = (out_len != '0);
  assign in_load = in_valid && (state_reg == PS_CMD2) && pair_bin_in;
  assign out_load = in_valid && (state_reg == PS_CMD2) && pair_bin_out;
  assign bin_start = in_load || out_load;
  assign out_clr = dev_clear || inst_preset || in_load;

  // command parser
  always_comb begin
    state_next = state_reg;
    first_next = first_reg;
    tens_next = tens_reg;
    staged_next = staged_reg;
    pend_next = pend_reg;
    active_next = active_reg;
    skip_eol_next = skip_eol_reg;
    srq_next = srq_reg && !(wr_en && hit_status && pwdata[tmb_pkg::STAT_SRQ_BIT]); // clear first, any set wins
    bcmd_next = bcmd_reg;
    if (in_valid) begin
      unique case (state_reg)
        PS_CMD1: begin
          if (is_letter) begin
            first_next = in_data;
            state_next = PS_CMD2;
          end else if (!is_sep) begin
            srq_next = 1'b1;
          end
        end
        PS_CMD2: begin
          state_next = PS_CMD1;
          if (pair == tmb_pkg::CMD_RECALL) begin
            state_next = PS_RC_DIG;
          end else if (pair_bin_in) begin
            state_next = PS_BIN_IN;
            skip_eol_next = 1'b1;
            bcmd_next = pair_cmd;
          end else if (pair_bin_out) begin
            skip_eol_next = 1'b1;
            bcmd_next = pair_cmd;
          end else if (!is_letter) begin
            srq_next = 1'b1;
          end
        end
        PS_RC_DIG: begin
          state_next = (in_data == tmb_pkg::CH_6) ? PS_TM_D1 : PS_CMD1;
          srq_next = srq_next || !is_digit;
        end
        PS_TM_D1: begin
          tens_next = digit;
          state_next = is_digit ? PS_TM_D2 : PS_CMD1;
          srq_next = srq_next || !is_digit;
        end
        PS_TM_D2: begin
          state_next = PS_CMD1;
          if (!is_digit) begin
            srq_next = 1'b1;
          end else if ((tens_reg == 4'h0) && (digit <= tmb_pkg::TM_BW_ADJ)) begin
            staged_next = digit;
            pend_next = 1'b1;
          end
          // codes above nine leave both staged and active modes alone
        end
        PS_BIN_IN: begin
          skip_eol_next = 1'b0;
          if (bin_byte && in_last) begin
            state_next = PS_CMD1;
            bcmd_next = tmb_pkg::BC_NONE;
          end
        end
        default: state_next = PS_CMD1;
      endcase
    end
    // a stray terminator after a binary output command is also swallowed
    if (in_valid && (state_reg == PS_CMD1) && skip_eol_reg) begin
      skip_eol_next = 1'b0;
    end
    srq_next = srq_next || cmd_reject;
    // output commands carry bit 2; drop them once the last word is taken
    if (!out_busy && bcmd_reg[2] && !bin_start) begin
      bcmd_next = tmb_pkg::BC_NONE;
    end
    // clear or preset makes the staged mode active, or ends the running one
    if (dev_clear || inst_preset) begin
      active_next = pend_reg ? staged_reg : tmb_pkg::TM_OFF;
      pend_next = 1'b0;
      state_next = PS_CMD1;
      bcmd_next = tmb_pkg::BC_NONE;
      skip_eol_next = 1'b0;
    end
  end

  // parser registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= PS_CMD1;
      first_reg <= 8'h00;
      tens_reg <= 4'h0;
      staged_reg <= tmb_pkg::TM_OFF;
      pend_reg <= 1'b0;
      active_reg <= tmb_pkg::TM_OFF;
      skip_eol_reg <= 1'b0;
      srq_reg <= 1'b0;
      bcmd_reg <= tmb_pkg::BC_NONE;
    end else begin
      state_reg <= state_next;
      first_reg <= first_next;
      tens_reg <= tens_next;
      staged_reg <= staged_next;
      pend_reg <= pend_next;
      active_reg <= active_next;
      skip_eol_reg <= skip_eol_next;
      srq_reg <= srq_next;
      bcmd_reg <= bcmd_next;
    end
  end

  // binary input words and forwarded commands, one-cycle pulses
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bin_valid_reg <= 1'b0;
      bin_data_reg <= 8'h00;
      bin_index_reg <= 12'h000;
      fwd_valid_reg <= 1'b0;
      fwd_cmd_reg <= 16'h0000;
    end else begin
      bin_valid_reg <= bin_byte;
      bin_data_reg <= bin_byte ? in_data : bin_data_reg;
      bin_index_reg <= bin_byte ? 12'(in_len_cur() - in_count) : bin_index_reg;
      fwd_valid_reg <= in_valid && (state_reg == PS_CMD2) && is_letter && !bin_start &&
                       (pair != tmb_pkg::CMD_RECALL);
      fwd_cmd_reg <= (in_valid && state_reg == PS_CMD2) ? pair : fwd_cmd_reg;
    end
  end

  // word count of the binary input in progress, for the index
  function automatic logic [11:0] in_len_cur();
    in_len_cur = (bcmd_reg == tmb_pkg::BC_LRN_IN) ? tmb_pkg::LRN_WORDS : tmb_pkg::TRACE_WORDS;
  endfunction

  // binary output streams as soon as the device is addressed to talk, with no trigger
  assign out_take = talk_addressed && out_busy && (!out_valid_reg || out_ready);
  assign out_word_addr = 12'(out_len_cur() - out_count);
  function automatic logic [11:0] out_len_cur();
    out_len_cur = (bcmd_reg == tmb_pkg::BC_LRN_OUT) ? tmb_pkg::LRN_WORDS : tmb_pkg::TRACE_WORDS;
  endfunction
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 8'h00;
    end else if (out_clr) begin
      out_valid_reg <= 1'b0;
    end else if (out_take) begin
      out_valid_reg <= 1'b1;
      out_data_reg <= out_word_data;
    end else if (out_ready) begin
      out_valid_reg <= 1'b0;
    end
  end

  // trigger and dump: a binary command ends both but the dump mode is kept
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trig_pend_reg <= 1'b0;
      dump_act_reg <= 1'b0;
    end else if (bin_start) begin
      trig_pend_reg <= 1'b0;
      dump_act_reg <= 1'b0;
    end else begin
      trig_pend_reg <= (trigger_in || (wr_en && hit_dump && pwdata[tmb_pkg::DUMP_TRIG_BIT])) ||
                       (trig_pend_reg && (in_busy || out_busy));
      dump_act_reg <= dump_act_reg || (trig_pend_reg && !in_busy && !out_busy && (dmode_reg != 2'b00));
    end
  end

  // software registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_reg <= tmb_pkg::CTRL_RST;
      step_reg <= tmb_pkg::STEP_RST;
      rbw_reg <= tmb_pkg::RBW_RST;
      rbw_change_reg <= 1'b0;
      dmode_reg <= 2'b00;
    end else begin
      ctrl_reg <= (wr_en && hit_ctrl) ? {30'h0000_0000, pwdata[1:0]} : ctrl_reg;
      step_reg <= (wr_en && hit_step) ? pwdata[19:0] : step_reg;
      rbw_reg <= (wr_en && hit_rbw) ? pwdata[3:0] : rbw_reg;
      rbw_change_reg <= wr_en && hit_rbw;
      dmode_reg <= (wr_en && hit_dump) ? pwdata[1:0] : dmode_reg;
    end
  end

  // read mux
  logic [31:0] status_word;
  assign status_word = {18'h00000, dump_act_reg, trig_pend_reg, srq_reg, out_busy, in_busy, pend_reg,
    staged_reg, active_reg};
  assign prdata = !rd_en ? 32'h0000_0000 :
    hit_ctrl ? ctrl_reg :
    hit_step ? {12'h000, step_reg} :
    hit_rbw ? {28'h0000000, rbw_reg} :
    hit_status ? status_word :
    hit_dump ? {30'h0000_0000, dmode_reg} : 32'h0000_0000;

  // active mode drives the instrument
  tmb_test_decode #(.BW_30K(BW_30K)) u_decode (
    .clk(clk), .rst_b(rst_b), .mode(active_reg), .center_step_size(step_reg),
    .resolution_bw_setting(rbw_reg), .rbw_change(rbw_change_reg),
    .counter_on(ctrl_reg[tmb_pkg::CTRL_CNT_BIT]), .rbw_calibrated(ctrl_reg[tmb_pkg::CTRL_RBWCAL_BIT]),
    .ctrl(tm_ctrl)
  );

  // outputs
  assign fwd_valid = fwd_valid_reg;
  assign fwd_cmd = fwd_cmd_reg;
  assign bin_in_valid = bin_valid_reg;
  assign bin_in_data = bin_data_reg;
  assign bin_in_index = bin_index_reg;
  assign bin_cmd = bcmd_reg;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;
  assign service_request_line = srq_reg;
  assign dump_active = dump_act_reg;
  assign dump_mode = dmode_reg;
endmodule
`default_nettype wire

// ### tmb_asserts.sv
// Purpose: port checks of the command handler
// Assumes: one clock, synchronous active-low reset
// Notes: ports grouped on lines to stay compact
`timescale 1ns/100ps
`default_nettype none
module tmb_asserts (
  // watched ports
  input wire logic clk, rst_b, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic dev_clear, inst_preset, cmd_reject, service_request_line, bin_in_valid,
  input wire logic [11:0] bin_in_index,
  input wire logic [1:0] dump_mode,
  input wire tmb_pkg::tmb_tm_ctrl_t tm_ctrl
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // decode of the access seen on the bus
  wire acc = psel && penable;
  wire bad = paddr > 8'h10 || paddr[1:0] != 2'h0;
  wire dw = acc && pwrite && paddr == 8'h10;
  zero_wait_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (pslverr == (acc && bad)) else $error("pslverr wrong");
  idle_rdata_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0) else $error("prdata not zero");
  srq_set_a: assert property (cmd_reject |=> service_request_line) else $error("no srq");
  // only a clear or preset two cycles back may move the calibration-disable and 10 MHz outputs
  mode_hold_a: assert property (!$past(dev_clear, 2) && !$past(inst_preset, 2) |-> $stable(tm_ctrl.cal_disable)
    && $stable(tm_ctrl.src_ref_10m)) else $error("mode moved");
  source_excl_a: assert property (!(tm_ctrl.src_ref_10m && tm_ctrl.src_tracking)) else $error("two sources");
  tg_cap_a: assert property (tm_ctrl.tg_offset <= tmb_pkg::STEP_TG_MAX) else $error("offset over cap");
  tune_excl_a: assert property (tm_ctrl.tune_coarse |-> !tm_ctrl.tune_fine_hold) else $error("both dacs");
  board_cal_a: assert property (tm_ctrl.board_prog != 3'h0 |-> tm_ctrl.cal_disable) else $error("board prog");
  bin_index_a: assert property (bin_in_valid |-> bin_in_index < tmb_pkg::TRACE_WORDS) else $error("index");
  dump_kept_a: assert property (!$past(dw) |-> $stable(dump_mode)) else $error("dump mode lost");
  cover property (tm_ctrl.src_ref_10m);
  cover property (bin_in_valid && bin_in_index == 12'h063);
  cover property (pslverr);
endmodule
bind tmb_cmd_handler tmb_asserts chk_u (.*);
`default_nettype wire

// ### tmb_ctl_model.sv
// Purpose: bus controller model feeding command bytes and bus events
// Assumes: called just after a rising edge
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/100ps
`default_nettype none
module tmb_ctl_model (
  // clock
  input wire logic clk,
  // byte stream and events
  output logic in_valid, dev_clear, inst_preset, talk_addressed,
  output logic [7:0] in_data
);
  initial {in_valid, dev_clear, inst_preset, talk_addressed, in_data} = 12'h0;
  // one byte a cycle, held valid between bytes of a string
  task automatic send(input logic [7:0] b);
    in_valid <= 1'b1;
    in_data <= b;
    @(posedge clk);
  endtask
  task automatic str(input string s);
    foreach (s[i]) send(s[i]);
  endtask
  task automatic idle();
    in_valid <= 1'b0;
    in_data <= ~in_data;
  endtask
  // activation of a staged code needs a clear or a preset
  task automatic clr(input logic pre);
    if (pre) inst_preset <= 1'b1;
    else dev_clear <= 1'b1;
    @(posedge clk);
    {dev_clear, inst_preset} <= 2'h0;
  endtask
  task automatic talk(input logic t);
    talk_addressed <= t;
  endtask
endmodule
`default_nettype wire

// ### test_mode_binary_cmd_handler_bench.sv
// Purpose: self-checking bench of the command handler
// Assumes: zero-wait apb, byte stream from the controller model
// Notes: output words are addr xor 5a so order is visible
`timescale 1ns/100ps
`default_nettype none
module test_mode_binary_cmd_handler_bench;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cmd_reject = 1'b0;
  logic out_ready = 1'b0, trigger_in = 1'b0, err, pready, pslverr, in_valid, dev_clear, inst_preset;
  logic talk_addressed, fwd_valid, bin_in_valid, out_valid, service_request_line, dump_active;
  logic [7:0] paddr = 8'h00, in_data, out_data, bin_in_data;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] fwd_cmd, last_cmd;
  logic [11:0] bin_in_index, out_word_addr;
  logic [3:0] r;
  logic [1:0] dump_mode;
  tmb_pkg::tmb_bin_cmd_t bin_cmd;
  tmb_pkg::tmb_tm_ctrl_t tm_ctrl;
  int errors = 0, n_checks = 0, n_in = 0, n_out = 0, cyc = 0;
  wire logic [7:0] out_word_data = out_word_addr[7:0] ^ 8'h5a;
  tmb_cmd_handler dut_u (.*);
  tmb_ctl_model ctl_u (.*);
  always #2.5 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // cal off, offsets off, 10 MHz in, tracking in, single loop, tune plot
  function automatic logic [5:0] exp_ctl(input int c);
    return {{2{c inside {1, 3, 5, 9}}}, c inside {2, 3}, c inside {4, 5}, c == 6, c == 8};
  endfunction
  // monitors, random consumer stalls and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    out_ready <= 1'($urandom);
    if (bin_in_valid === 1'b1) n_in <= n_in + 1;
    if (fwd_valid === 1'b1) last_cmd <= fwd_cmd;
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      chk("out_data", n_out[7:0] ^ 8'h5a, out_data);
      n_out <= n_out + 1;
    end
    if (cyc > 5000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'hbefa3214));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b1, tmb_pkg::OFS_CTRL, 32'h3);
    for (int c = 0; c < 10; c++) begin
      ctl_u.str($sformatf("RC60%0d", c));
      ctl_u.idle();
      apb(1'b0, tmb_pkg::OFS_STATUS, 32'h0);
      chk("staged", {1'b1, 4'(c), 4'(c == 0 ? 0 : c - 1)}, rd[8:0]);
      ctl_u.clr(1'(c));
      repeat (3) @(posedge clk);
      chk("ctl", exp_ctl(c), {tm_ctrl[43:39], tm_ctrl.tune_plot_en});
    end
    ctl_u.str("RC612");
    ctl_u.idle();
    apb(1'b0, tmb_pkg::OFS_STATUS, 32'h0);
    chk("refused", 5'h09, {rd[8], rd[3:0]});
    r = 4'($urandom);
    apb(1'b1, tmb_pkg::OFS_STEP, 32'(tmb_pkg::STEP_BOARD2));
    apb(1'b1, tmb_pkg::OFS_RBW, 32'(r));
    repeat (3) @(posedge clk);
    chk("boards", {tmb_pkg::BW_CODE_30K, r, tmb_pkg::BW_CODE_30K}, tm_ctrl.board_bw);
    ctl_u.str("LI\015");
    repeat (100) ctl_u.send(8'($urandom));
    ctl_u.str("XY");
    ctl_u.idle();
    repeat (3) @(posedge clk);
    chk("bin bytes", 32'd100, n_in);
    chk("ascii back", 16'h5859, last_cmd);
    chk("bin cmd", 32'h0, 32'(bin_cmd));
    apb(1'b1, tmb_pkg::OFS_DUMP, {29'h0, 1'b1, r[1:0]});
    ctl_u.str("LO");
    ctl_u.idle();
    repeat (2) @(posedge clk);
    apb(1'b0, tmb_pkg::OFS_STATUS, 32'h0);
    chk("dump", {1'b0, r[1:0]}, {rd[12], dump_mode});
    ctl_u.talk(1'b1);
    while (n_out < 100) @(posedge clk);
    repeat (5) @(posedge clk);
    chk("out bytes", 32'd100, n_out);
    cmd_reject <= 1'b1;
    @(posedge clk);
    cmd_reject <= 1'b0;
    @(posedge clk);
    chk("srq", 1'b1, service_request_line);
    apb(1'b1, tmb_pkg::OFS_STATUS, 32'h800);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h8000_0000, {err, rd[30:0]});
    chk("srq clr", 1'b0, service_request_line);
    complete_run();
  end
endmodule
`default_nettype wire
